// ### ssc_device.sv
// Operation
// RULE1 - 08h enters run, 09h enters setup
// RULE2 - Master sends zero address and reserved halfword
// RULE3 - Transition frames ignore data, output indeterminate
// RULE4 - 00h only returns status words
// RULE5 - Header returns comm status then state word
// RULE6 - Master sends setup command only when stopped
// RULE7 - Master waits for previous transition to finish
// RULE8 - Status reflects the preceding frame's result
// RULE9 - Bits 15:14 hold request, reset 01
// RULE10 - Error flags at bits 13,12,10,9,8
// RULE11 - Bit 11 reserved, any value
// RULE12 - Eight-bit error tally, wraps FFh to 00h
// RULE13 - Flags sticky until clear bit rises
// RULE14 - Tally zeroed only on clear bit rising
// RULE15 - Bad clock count or overrun: clock fault
// RULE16 - Select rising before header end: short header
// RULE17 - Range fault discards only offending data
// RULE18 - Undefined command: unknown command fault, discard
// RULE19 - Impossible transition: transition fault, discard
// RULE20 - State word bit 15 reports present state
// RULE21 - Run while running applies no settings
// RULE22 - Return to setup keeps stored settings
// RULE23 - Select falling restarts bit counters
`timescale 1ns/10ps
module ssc_device (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   // Link
   ssc_link_if.device       link,
   // User side
   input  wire logic [7:0]  alarm_code_i,
   input  wire logic        range_fault_i,
   input  wire logic        error_clear_bit_i,
   output logic             run_state_o,
   output logic             apply_settings_o,
   output logic [15:0]      comm_status_word_o
);
   // ****************************************
   // State
   // ****************************************
   logic [2:0]  sck_sync_r,  sck_sync_nxt;
   logic [2:0]  ss_sync_r,   ss_sync_nxt;
   logic [1:0]  mosi_sync_r, mosi_sync_nxt;
   logic        frame_r,     frame_nxt;
   logic [9:0]  bitcnt_r,    bitcnt_nxt;
   logic        overrun_r,   overrun_nxt;
   logic [7:0]  cmd_r,       cmd_nxt;
   logic [31:0] tx_r,        tx_nxt;
   logic        miso_r,      miso_nxt;
   logic        miso_oe_n_r, miso_oe_n_nxt;
   logic [1:0]  req_r,       req_nxt;
   logic [4:0]  flags_r,     flags_nxt;
   logic [7:0]  tally_r,     tally_nxt;
   logic        run_r,       run_nxt;
   logic        pend_r,      pend_nxt;
   logic [7:0]  timer_r,     timer_nxt;
   logic        apply_r,     apply_nxt;
   logic        clr_d_r,     clr_d_nxt;

   logic        sck_rise;
   logic        sck_fall;
   logic        ss_fall;
   logic        ss_rise;
   logic        clear_evt;
   logic        frame_clock_fault;
   logic        short_header_fault;
   logic        cmd_err;
   logic        transition_fail_fault;
   logic        frame_err;
   logic        is_run;
   logic        is_setup;
   logic        known_cmd;
   logic [15:0] status_word;
   logic [15:0] state_word;
   logic [4:0]  flag_set;

   // ****************************************
   // Combinational next state
   // ****************************************
   always_comb begin
      sck_sync_nxt  = {sck_sync_r[1:0], link.sclk};
      ss_sync_nxt   = {ss_sync_r[1:0], link.ss_n};
      mosi_sync_nxt = {mosi_sync_r[0], link.mosi};
      sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
      sck_fall = ~sck_sync_r[1] & sck_sync_r[2];
      ss_fall  = ~ss_sync_r[1] & ss_sync_r[2];
      ss_rise  = ss_sync_r[1] & ~ss_sync_r[2];

      status_word = {req_r, flags_r[4:3], 1'b0, flags_r[2:0], tally_r}; // RULE9 RULE11
      state_word  = {run_r, 7'h00, alarm_code_i}; // RULE20

      frame_nxt     = frame_r;
      bitcnt_nxt    = bitcnt_r;
      overrun_nxt   = overrun_r;
      cmd_nxt       = cmd_r;
      tx_nxt        = tx_r;
      miso_nxt      = miso_r;
      miso_oe_n_nxt = miso_oe_n_r;
      req_nxt       = req_r;
      run_nxt       = run_r;
      pend_nxt      = pend_r;
      timer_nxt     = timer_r;
      apply_nxt     = 1'b0;
      clr_d_nxt     = error_clear_bit_i;

      // Snapshot status at frame start so the word stays stable while shifting
      if (ss_fall) begin
         frame_nxt     = 1'b1;
         bitcnt_nxt    = 10'h000; // RULE23
         overrun_nxt   = 1'b0;
         cmd_nxt       = 8'h00;
         tx_nxt        = {status_word, state_word}; // RULE5 RULE8
         miso_oe_n_nxt = 1'b0;
      end else if (frame_r) begin
         if (sck_rise) begin
            if (bitcnt_r == ssc_pkg::MAX_BITS_C) begin
               overrun_nxt = 1'b1; // RULE15
            end else begin
               bitcnt_nxt = bitcnt_r + 10'h001;
            end
            if (bitcnt_r < ssc_pkg::CMD_BITS_C) begin
               cmd_nxt = {cmd_r[6:0], mosi_sync_r[1]};
            end
         end
         // Data field shifts out zeros as the indeterminate filler
         if (sck_fall) begin
            miso_nxt = tx_r[31]; // RULE3 RULE4
            tx_nxt   = {tx_r[30:0], 1'b0};
         end
      end

      // ****************************************
      // End-of-frame evaluation
      // ****************************************
      is_run    = (cmd_r == ssc_pkg::ENTER_RUN_CMD);
      is_setup  = (cmd_r == ssc_pkg::ENTER_SETUP_CMD);
      known_cmd = is_run | is_setup | (cmd_r == ssc_pkg::IDLE_CMD) |
                  (cmd_r == ssc_pkg::WRITE_CMD) | (cmd_r == ssc_pkg::READ_CMD); // RULE1
      frame_clock_fault  = (bitcnt_r == 10'h000) | (bitcnt_r[3:0] != 4'h0) | overrun_r; // RULE15
      short_header_fault = ~frame_clock_fault & (bitcnt_r < ssc_pkg::HDR_BITS_C); // RULE16
      cmd_err = ~frame_clock_fault & ~short_header_fault & ~known_cmd; // RULE18
      // A second request while one is still executing cannot be honoured
      transition_fail_fault = ~frame_clock_fault & ~short_header_fault & (is_run | is_setup) & pend_r; // RULE19 RULE7
      frame_err = ss_rise & frame_r & (frame_clock_fault | short_header_fault | cmd_err | transition_fail_fault);

      if (ss_rise & frame_r) begin
         frame_nxt     = 1'b0;
         miso_oe_n_nxt = 1'b1;
         // Address byte is never examined by this block
         if (~frame_err & (is_run | is_setup)) begin // RULE2
            req_nxt   = is_run ? ssc_pkg::REQ_RUN : ssc_pkg::REQ_SETUP; // RULE1 RULE9
            pend_nxt  = 1'b1;
            timer_nxt = ssc_pkg::TRANS_CYC;
         end
      end

      // ****************************************
      // State transition execution
      // ****************************************
      if (pend_r) begin
         if (timer_r == 8'h00) begin
            pend_nxt = 1'b0;
            run_nxt  = (req_r == ssc_pkg::REQ_RUN); // RULE20
            // Settings only load when leaving setup, never on a repeat
            apply_nxt = (req_r == ssc_pkg::REQ_RUN) & ~run_r; // RULE21 RULE22
         end else begin
            timer_nxt = timer_r - 8'h01;
         end
      end

      // ****************************************
      // Error flags and tally
      // ****************************************
      clear_evt = error_clear_bit_i & ~clr_d_r; // RULE13 RULE14
      flag_set  = {ss_rise & frame_r & frame_clock_fault,
                   ss_rise & frame_r & short_header_fault,
                   range_fault_i, // RULE17
                   ss_rise & frame_r & cmd_err,
                   ss_rise & frame_r & transition_fail_fault}; // RULE10
      // Set wins over a clear in the same cycle
      flags_nxt = (clear_evt ? 5'h00 : flags_r) | flag_set; // RULE13
      tally_nxt = (clear_evt ? ssc_pkg::TALLY_RESET : tally_r) +
                  {7'h00, frame_err} + {7'h00, range_fault_i}; // RULE12 RULE14
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sck_sync_r  <= 3'h7;
         ss_sync_r   <= 3'h7;
         mosi_sync_r <= 2'h0;
         frame_r     <= 1'b0;
         bitcnt_r    <= 10'h000;
         overrun_r   <= 1'b0;
         cmd_r       <= 8'h00;
         tx_r        <= 32'h0000_0000;
         miso_r      <= 1'b0;
         miso_oe_n_r <= 1'b1;
         req_r       <= ssc_pkg::REQ_SETUP; // RULE9
         flags_r     <= 5'h00;
         tally_r     <= ssc_pkg::TALLY_RESET; // RULE12
         run_r       <= 1'b0;
         pend_r      <= 1'b0;
         timer_r     <= 8'h00;
         apply_r     <= 1'b0;
         clr_d_r     <= 1'b0;
      end else begin
         sck_sync_r  <= sck_sync_nxt;
         ss_sync_r   <= ss_sync_nxt;
         mosi_sync_r <= mosi_sync_nxt;
         frame_r     <= frame_nxt;
         bitcnt_r    <= bitcnt_nxt;
         overrun_r   <= overrun_nxt;
         cmd_r       <= cmd_nxt;
         tx_r        <= tx_nxt;
         miso_r      <= miso_nxt;
         miso_oe_n_r <= miso_oe_n_nxt;
         req_r       <= req_nxt;
         flags_r     <= flags_nxt;
         tally_r     <= tally_nxt;
         run_r       <= run_nxt;
         pend_r      <= pend_nxt;
         timer_r     <= timer_nxt;
         apply_r     <= apply_nxt;
         clr_d_r     <= clr_d_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign link.miso          = miso_r;
   assign link.miso_oe_n     = miso_oe_n_r;
   assign run_state_o        = run_r;
   assign apply_settings_o   = apply_r;
   assign comm_status_word_o = {req_r, flags_r[4:3], 1'b0, flags_r[2:0], tally_r};
endmodule // ssc_device

// ### ssc_pkg.sv
package ssc_pkg;
   // ****************************************
   // Frame layout
   // ****************************************
   localparam int          HDR_BITS     = 32;
   localparam int          WORD_BITS    = 16;
   localparam int          MAX_WORDS    = 32;
   localparam logic [9:0]  HDR_BITS_C   = 10'h020;
   localparam logic [9:0]  MAX_BITS_C   = 10'h220;
   localparam logic [9:0]  CMD_BITS_C   = 10'h008;
   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0]  IDLE_CMD      = 8'h00;
   localparam logic [7:0]  WRITE_CMD     = 8'h02;
   localparam logic [7:0]  READ_CMD      = 8'h03;
   localparam logic [7:0]  ENTER_RUN_CMD = 8'h08;
   localparam logic [7:0]  ENTER_SETUP_CMD = 8'h09;
   localparam logic [7:0]  ADDR_FILL     = 8'h00;
   localparam logic [15:0] RESERVED_FILL = 16'h0000;
   // ****************************************
   // Communication status word
   // ****************************************
   localparam logic [1:0]  REQ_SETUP     = 2'h1;
   localparam logic [1:0]  REQ_RUN       = 2'h2;
   localparam int          REQ_POS       = 14;
   localparam int          FRAME_CLK_POS = 13;
   localparam int          SHORT_HDR_POS = 12;
   localparam int          RANGE_POS     = 10;
   localparam int          UNK_CMD_POS   = 9;
   localparam int          TRANS_POS     = 8;
   localparam logic [7:0]  TALLY_RESET   = 8'h00;
   // ****************************************
   // Timing
   // ****************************************
   localparam int          CLK_PERIOD_NS  = 10;
   // Longest the 8-bit timer holds, so a fast host can overlap a transition
   localparam int          TRANS_TIME_NS  = 2550;
   localparam logic [7:0]  TRANS_CYC      = 8'(TRANS_TIME_NS / CLK_PERIOD_NS);
   localparam logic [3:0]  SCK_HALF_CYC   = 4'h8;
endpackage : ssc_pkg

// ### ssc_link_if.sv
`timescale 1ns/10ps
interface ssc_link_if;
   logic sclk;
   logic ss_n;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   logic miso_line;

   // Pulled high while the device releases the line
   assign miso_line = miso_oe_n ? 1'b1 : miso;

   modport device (
      input  sclk,
      input  ss_n,
      input  mosi,
      output miso,
      output miso_oe_n
   );

   modport host (
      output sclk,
      output ss_n,
      output mosi,
      input  miso_line
   );
endinterface : ssc_link_if

// ### ssc_host.sv
`timescale 1ns/10ps
module ssc_host (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   // Link
   ssc_link_if.host         link,
   // User side
   input  wire logic        start_i,
   input  wire logic [7:0]  cmd_i,
   input  wire logic [5:0]  words_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [15:0]      status0_o,
   output logic [15:0]      status1_o
);
   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} ssc_hst_t;

   // ****************************************
   // State
   // ****************************************
   ssc_hst_t    st_r,    st_nxt;
   logic [3:0]  div_r,   div_nxt;
   logic [9:0]  bit_r,   bit_nxt;
   logic [9:0]  total_r, total_nxt;
   logic [31:0] tx_r,    tx_nxt;
   logic [31:0] rx_r,    rx_nxt;
   logic [1:0]  miso_sync_r, miso_sync_nxt;
   logic        sclk_r,  sclk_nxt;
   logic        ss_n_r,  ss_n_nxt;
   logic        mosi_r,  mosi_nxt;
   logic        busy_r,  busy_nxt;
   logic        done_r,  done_nxt;
   logic [15:0] s0_r,    s0_nxt;
   logic [15:0] s1_r,    s1_nxt;
   logic [9:0]  bit_inc;

   // ****************************************
   // Combinational next state
   // ****************************************
   always_comb begin
      miso_sync_nxt = {miso_sync_r[0], link.miso_line};
      st_nxt    = st_r;
      div_nxt   = (div_r == 4'h0) ? 4'h0 : div_r - 4'h1;
      bit_nxt   = bit_r;
      total_nxt = total_r;
      tx_nxt    = tx_r;
      rx_nxt    = rx_r;
      sclk_nxt  = sclk_r;
      ss_n_nxt  = ss_n_r;
      mosi_nxt  = mosi_r;
      busy_nxt  = busy_r;
      done_nxt  = 1'b0;
      s0_nxt    = s0_r;
      s1_nxt    = s1_r;
      bit_inc   = bit_r + 10'h001;
      case (st_r)
         ST_IDLE: begin
            if (start_i) begin
               // Address and reserved halfword always zero
               tx_nxt    = {cmd_i, ssc_pkg::ADDR_FILL, ssc_pkg::RESERVED_FILL}; // RULE1 RULE2
               total_nxt = ssc_pkg::HDR_BITS_C + {words_i, 4'h0};
               bit_nxt   = 10'h000;
               ss_n_nxt  = 1'b0;
               busy_nxt  = 1'b1;
               div_nxt   = ssc_pkg::SCK_HALF_CYC - 4'h1;
               st_nxt    = ST_LEAD;
            end
         end
         ST_LEAD, ST_HIGH: begin
            if (div_r == 4'h0) begin
               if (st_r == ST_HIGH) begin
                  rx_nxt  = {rx_r[30:0], miso_sync_r[1]};
                  bit_nxt = bit_inc;
                  if (bit_inc == ssc_pkg::HDR_BITS_C) begin
                     s0_nxt = rx_nxt[31:16];
                     s1_nxt = rx_nxt[15:0];
                  end
               end
               if ((st_r == ST_HIGH) && (bit_inc == total_r)) begin
                  div_nxt = ssc_pkg::SCK_HALF_CYC - 4'h1;
                  st_nxt  = ST_TAIL;
               end else begin
                  // Data field words are sent as zeros
                  sclk_nxt = 1'b0;
                  mosi_nxt = tx_r[31];
                  tx_nxt   = {tx_r[30:0], 1'b0};
                  div_nxt  = ssc_pkg::SCK_HALF_CYC - 4'h1;
                  st_nxt   = ST_LOW;
               end
            end
         end
         ST_LOW: begin
            if (div_r == 4'h0) begin
               sclk_nxt = 1'b1;
               div_nxt  = ssc_pkg::SCK_HALF_CYC - 4'h1;
               st_nxt   = ST_HIGH;
            end
         end
         ST_TAIL: begin
            if (div_r == 4'h0) begin
               ss_n_nxt = 1'b1;
               mosi_nxt = 1'b0;
               div_nxt  = ssc_pkg::SCK_HALF_CYC - 4'h1;
               st_nxt   = ST_GAP;
            end
         end
         ST_GAP: begin
            // Gap lets the device see select high before a new frame
            if (div_r == 4'h0) begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               st_nxt   = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st_r        <= ST_IDLE;
         div_r       <= 4'h0;
         bit_r       <= 10'h000;
         total_r     <= 10'h000;
         tx_r        <= 32'h0000_0000;
         rx_r        <= 32'h0000_0000;
         miso_sync_r <= 2'h3;
         sclk_r      <= 1'b1;
         ss_n_r      <= 1'b1;
         mosi_r      <= 1'b0;
         busy_r      <= 1'b0;
         done_r      <= 1'b0;
         s0_r        <= 16'h0000;
         s1_r        <= 16'h0000;
      end else begin
         st_r        <= st_nxt;
         div_r       <= div_nxt;
         bit_r       <= bit_nxt;
         total_r     <= total_nxt;
         tx_r        <= tx_nxt;
         rx_r        <= rx_nxt;
         miso_sync_r <= miso_sync_nxt;
         sclk_r      <= sclk_nxt;
         ss_n_r      <= ss_n_nxt;
         mosi_r      <= mosi_nxt;
         busy_r      <= busy_nxt;
         done_r      <= done_nxt;
         s0_r        <= s0_nxt;
         s1_r        <= s1_nxt;
      end
   end

   assign link.sclk = sclk_r;
   assign link.ss_n = ss_n_r;
   assign link.mosi = mosi_r;
   assign busy_o    = busy_r;
   assign done_o    = done_r;
   assign status0_o = s0_r;
   assign status1_o = s1_r;
endmodule // ssc_host

// ### ssc_checker.sv
`timescale 1ns/10ps
module ssc_checker (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   // Link
   input  wire logic        sclk,
   input  wire logic        ss_n,
   input  wire logic        miso_oe_n,
   // Device side
   input  wire logic        error_clear_bit_i,
   input  wire logic        run_state_o,
   input  wire logic        apply_settings_o,
   input  wire logic [15:0] comm_status_word_o
);
   logic [2:0]  clr_r;
   logic [2:0]  clr_nxt;
   logic        clr_seen;
   logic [15:0] w;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   // ****************
   // Clear history
   // ****************
   always_comb begin
      clr_nxt = {clr_r[1:0], error_clear_bit_i};
   end
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         clr_r <= 3'h0;
      end else begin
         clr_r <= clr_nxt;
      end
   end
   // Clear lands one edge after its rise; either edge tolerated
   assign clr_seen = (clr_r[0] & ~clr_r[1]) | (clr_r[1] & ~clr_r[2]);
   assign w = comm_status_word_o;

   // ****************
   // Properties
   // ****************
   a_req_legal: assert property (w[15:14] inside {2'h1, 2'h2})
      else $error("request field illegal");
   a_req_frame_end: assert property (
      $changed(w[15:14]) |-> ss_n && $past(ss_n, 2))
      else $error("request changed inside a frame");
   a_tally_step: assert property (
      w[7:0] != $past(w[7:0]) |-> w[7:0] == $past(w[7:0]) + 8'h01
         || w[7:0] == $past(w[7:0]) + 8'h02 || clr_seen)
      else $error("error tally jumped");
   a_flag_sticky: assert property (
      |($past(w) & ~w & 16'h3700) |-> clr_seen)
      else $error("error flag dropped without clear");
   a_run_req: assert property (
      $changed(run_state_o) |-> w[15:14] == (run_state_o ? 2'h2 : 2'h1))
      else $error("state moved against request");
   a_apply_run: assert property (
      apply_settings_o |-> run_state_o && w[15:14] == ssc_pkg::REQ_RUN)
      else $error("settings applied outside run entry");
   a_apply_pulse: assert property (apply_settings_o |=> !apply_settings_o)
      else $error("apply pulse too long");
   a_oe_select: assert property ($fell(ss_n) |-> ##[1:6] !miso_oe_n)
      else $error("device did not drive after select");
   a_oe_idle: assert property (ss_n [*6] |-> miso_oe_n)
      else $error("device drives while deselected");
   a_sclk_idle: assert property (ss_n |-> sclk)
      else $error("serial clock low outside frame");

   c_run: cover property ($rose(run_state_o));
   c_apply: cover property (apply_settings_o);
   c_unknown: cover property ($rose(w[9]));
   c_clear: cover property (clr_seen);
endmodule // ssc_checker

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
   // ****************
   // Bench state
   // ****************
   logic        clock_i, resetn_i, start_i, busy_o, done_o;
   logic [7:0]  cmd_i, alarm_a, alarm_b;
   logic [5:0]  words_i;
   logic [15:0] status0_o, status1_o, cs_a, cs_b, exp_cs;
   logic        range_a, range_b, clr_a, clr_b, run_a, run_b, apply_a, apply_b, exp_run;
   logic [31:0] seed, got;
   logic [31:0] exp_q[$];
   int          n_fail, total_checks, n_apply, half;

   ssc_link_if link_a ();
   ssc_link_if link_b ();
   ssc_host ssc_host_inst (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_a),
      .start_i(start_i), .cmd_i(cmd_i), .words_i(words_i), .busy_o(busy_o),
      .done_o(done_o), .status0_o(status0_o), .status1_o(status1_o));
   ssc_device ssc_device_inst (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_a),
      .alarm_code_i(alarm_a), .range_fault_i(range_a), .error_clear_bit_i(clr_a),
      .run_state_o(run_a), .apply_settings_o(apply_a), .comm_status_word_o(cs_a));
   // Second device faces the bench, which breaks framing on purpose
   ssc_device ssc_device_b_inst (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_b),
      .alarm_code_i(alarm_b), .range_fault_i(range_b), .error_clear_bit_i(clr_b),
      .run_state_o(run_b), .apply_settings_o(apply_b), .comm_status_word_o(cs_b));
   ssc_checker ssc_checker_inst (.clock_i(clock_i), .resetn_i(resetn_i),
      .sclk(link_a.sclk), .ss_n(link_a.ss_n), .miso_oe_n(link_a.miso_oe_n),
      .error_clear_bit_i(clr_a), .run_state_o(run_a), .apply_settings_o(apply_a),
      .comm_status_word_o(cs_a));

   always #(ssc_pkg::CLK_PERIOD_NS / 2) clock_i = ~clock_i;

   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Host frame: note the expected header words, then wait for done
   task automatic frame(input logic [7:0] cmd);
      int k;
      seed = xs(seed);
      alarm_a = seed[7:0];
      words_i = 6'(seed[10:8]);
      cmd_i = cmd;
      exp_q.push_back({exp_cs, exp_run, 7'h00, seed[7:0]});
      start_i = 1'b1;
      @(negedge clock_i);
      start_i = 1'b0;
      check("busy", busy_o, 1'b1);
      for (k = 0; k < 20000 && done_o !== 1'b1; k++) @(negedge clock_i);
      if (k == 20000) begin
         n_fail++;
         end_of_test();
      end
      @(negedge clock_i);
   endtask

   task automatic wait_run(input logic want);
      int k;
      for (k = 0; k < 300 && run_a !== want; k++) @(negedge clock_i);
      check("run state", run_a, want);
      exp_run = want;
      if (k == 300) end_of_test();
   endtask

   // Bench as master on the second link; n may break the framing
   task automatic bang(input int n, input logic [31:0] d);
      int k;
      got = 32'h0;
      link_b.ss_n = 1'b0;
      repeat (10) @(negedge clock_i);
      for (k = 0; k < n; k++) begin
         link_b.sclk = 1'b0;
         link_b.mosi = (k < 32) ? d[31-k] : 1'b0;
         repeat (half) @(negedge clock_i);
         got = {got[30:0], link_b.miso_line};
         link_b.sclk = 1'b1;
         repeat (half) @(negedge clock_i);
      end
      repeat (8) @(negedge clock_i);
      link_b.ss_n = 1'b1;
      link_b.mosi = ~link_b.mosi;
      repeat (12) @(negedge clock_i);
   endtask

   task automatic pulse(input int n);
      int k;
      for (k = 0; k < n; k++) begin
         range_b = 1'b1;
         @(negedge clock_i);
         range_b = 1'b0;
         @(negedge clock_i);
      end
      repeat (3) @(negedge clock_i);
   endtask

   // ****************
   // Monitor
   // ****************
   always @(negedge clock_i) begin
      if (apply_a === 1'b1) n_apply++;
      if (apply_b === 1'b1) n_apply++;
      if (done_o === 1'b1) begin
         if (exp_q.size() == 0) check("frame count", 32'h1, 32'h0);
         else check("header words", {status0_o, status1_o}, exp_q.pop_front());
      end
   end

   initial begin
      clock_i = 1'b0;
      resetn_i = 1'b0;
      start_i = 1'b0;
      cmd_i = 8'h00;
      words_i = 6'h00;
      alarm_a = 8'h00;
      range_a = 1'b0;
      range_b = 1'b0;
      clr_a = 1'b0;
      clr_b = 1'b0;
      link_b.sclk = 1'b1;
      link_b.ss_n = 1'b1;
      link_b.mosi = 1'b0;
      n_fail = 0;
      total_checks = 0;
      n_apply = 0;
      half = 8;
      exp_run = 1'b0;
      exp_cs = 16'h4000;
      seed = xs(32'hC97CBE44);
      alarm_b = seed[7:0];
      repeat (10) @(negedge clock_i);
      resetn_i = 1'b1;
      @(negedge clock_i);
      check("status reset", cs_a, 16'h4000);
      frame(ssc_pkg::IDLE_CMD);
      check("idle status", cs_a, exp_cs);
      frame(ssc_pkg::ENTER_RUN_CMD);
      exp_cs = 16'h8000;
      check("run request", cs_a, exp_cs);
      wait_run(1'b1);
      @(negedge clock_i);
      check("apply count", n_apply, 1);
      frame(ssc_pkg::ENTER_RUN_CMD);
      repeat (300) @(negedge clock_i);
      check("repeat run apply", n_apply, 1);
      frame(8'h55);
      exp_cs = 16'h8201;
      check("unknown command", cs_a, exp_cs);
      frame(ssc_pkg::ENTER_SETUP_CMD);
      exp_cs = 16'h4201;
      check("setup request", cs_a, exp_cs);
      wait_run(1'b0);
      frame(ssc_pkg::IDLE_CMD);
      clr_a = 1'b1;
      repeat (3) @(negedge clock_i);
      check("clear a", cs_a, 16'h4000);
      check("setup apply", n_apply, 1);
      bang(32, 32'h0);
      check("wire header", got, {16'h4000, 8'h00, alarm_b});
      check("idle b", cs_b, 16'h4000);
      bang(48, 32'h09000000);
      check("data filler", got, {8'h00, alarm_b, 16'h0000});
      bang(0, 32'h0);
      check("no clock", cs_b, 16'h6001);
      bang(16, 32'h0);
      check("short header", cs_b, 16'h7002);
      bang(20, 32'h0);
      check("odd count", cs_b, 16'h7003);
      bang(32, 32'hFF000000);
      check("previous result", got[31:16], 16'h7003);
      check("unknown b", cs_b, 16'h7204);
      bang(32, 32'h08000000);
      check("run b", cs_b, 16'hB204);
      // Fast frame lands while the run transition is still pending
      half = 3;
      bang(32, 32'h09000000);
      half = 8;
      check("refused setup", cs_b, 16'hB305);
      pulse(1);
      check("range", cs_b, 16'hB706);
      clr_b = 1'b1;
      repeat (3) @(negedge clock_i);
      check("clear b", cs_b, 16'h8000);
      clr_b = 1'b0;
      pulse(255);
      check("tally top", cs_b, 16'h84FF);
      check("run state b", run_b, 1'b1);
      pulse(1);
      check("tally wrap", cs_b, 16'h8400);
      bang(560, 32'h0);
      check("overrun", cs_b, 16'hA401);
      check("apply b", n_apply, 2);
      end_of_test();
   end
endmodule // tb_top
